/* File: sfb_pkg.sv */
// shared types and constants for the function bridge
package sfb_pkg;
  localparam int DATA_W    = 64;
  localparam int NUM_PF    = 8;
  localparam int NUM_VF    = 2048;
  localparam int PF_W      = 3;
  localparam int VF_W      = 11;
  localparam int BAR_N     = 2;
  localparam int CFG_IDX_W = 4;
  localparam int LMP_DW    = 32;
  // tlp fmt/type codes of the first header beat
  localparam logic [7:0] TYP_MRD   = 8'h00;
  localparam logic [7:0] TYP_MWR   = 8'h40;
  localparam logic [7:0] TYP_CFGRD = 8'h04;
  localparam logic [7:0] TYP_CFGWR = 8'h44;
  localparam logic [7:0] TYP_CPL   = 8'h0a;
  localparam logic [7:0] TYP_CPLD  = 8'h4a;
  localparam logic [7:0] TYP_MSG   = 8'h34;
  localparam logic [2:0] CPL_SC    = 3'h0;
  localparam logic [2:0] CPL_UR    = 3'h1;
  localparam logic [7:0] MSG_ASSERT_INTA   = 8'h20;
  localparam logic [7:0] MSG_DEASSERT_INTA = 8'h24;
  localparam logic [7:0] MSG_ERR_COR       = 8'h30;
  localparam logic [7:0] MSG_ERR_NONFATAL  = 8'h31;
  // config dword index map inside each function
  localparam logic [CFG_IDX_W-1:0] CFG_CMD    = 4'h1;
  localparam logic [CFG_IDX_W-1:0] CFG_BAR0   = 4'h4;
  localparam logic [CFG_IDX_W-1:0] CFG_BAR1   = 4'h5;
  localparam logic [CFG_IDX_W-1:0] CFG_MSI_AD = 4'h8;
  localparam logic [CFG_IDX_W-1:0] CFG_MSI_DT = 4'h9;
  localparam logic [CFG_IDX_W-1:0] CFG_DEVCTL = 4'ha;
  localparam logic [CFG_IDX_W-1:0] CFG_ATS    = 4'hb;
  localparam logic [CFG_IDX_W-1:0] CFG_TPH    = 4'hc;
  localparam int CMD_MEM_EN_BIT = 1;
  localparam int CMD_INTX_DIS_BIT = 10;
  localparam logic [31:0] BAR_SIZE_MASK = 32'hfff0_0000;

  typedef struct packed {
    logic              sop;
    logic              eop;
    logic [DATA_W-1:0] data;
  } sfb_beat_s;

  typedef struct packed {
    logic                 vf_active;
    logic [PF_W-1:0]      pf;
    logic [VF_W-1:0]      vf;
    logic [CFG_IDX_W-1:0] idx;
  } sfb_fn_s;

  typedef struct packed {
    logic [PF_W-1:0] pf;
    logic [VF_W-1:0] vf;
    logic            vf_active;
    logic            mem_en;
    logic            intx_dis;
    logic [15:0]     devctl;
  } sfb_mirror_s;
endpackage

/* File: sfb_skid.sv */
`timescale 1ns/10ps
`default_nettype none
// two-entry buffer with valid/ready on both sides
module sfb_skid #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data  = mem_q[rp_q];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) mem_q[wp_q] <= i_data;
  end
endmodule
`default_nettype wire

/* File: sfb_bridge.sv */
`timescale 1ns/10ps
`default_nettype none
// function bridge between hard transaction core and the application
// Notes on behaviour
// - bridge owns config space and BAR matching
// - config space for 8 PF, 2048 VF per PF
// - ATS and TPH capability words held
// - mirror port shows VF control fields
// - received BAR-hit memory, completions, messages pass unchanged
// - no outstanding request tracking state kept
// - completions delivered in arrival order
// - no completion to request matching
// - received config TLPs routed to config block
// - each config TLP answered by completion
// - MSI, MSI-X and INTx messages generated
// - AER error messages generated
// - transmit muxes app requests, completions, bridge traffic
// - UR completions merged into transmit
// - app memory requests forwarded unchecked
// - memory address compared to target BARs
// - BAR hit marked as PF or VF
// - BAR misses dropped, never delivered
// - failed memory reads get UR completion
// - management port steers to core or config
// - MSI for physical functions only
// - MSI-X for both PF and VF
module sfb_bridge
  import sfb_pkg::*;
#(
  parameter int N_PF = NUM_PF,
  parameter int N_VF = NUM_VF
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  // receive stream from the core, pass-through mode
  input  wire logic                  i_rx_valid,
  output logic                       o_rx_ready,
  input  wire sfb_pkg::sfb_beat_s    i_rx_beat,
  input  wire sfb_pkg::sfb_fn_s      i_rx_fn,
  // receive stream to the application
  output logic                       o_app_rx_valid,
  input  wire logic                  i_app_rx_ready,
  output sfb_pkg::sfb_beat_s         o_app_rx_beat,
  output logic                       o_app_rx_vf_hit,
  // application transmit stream
  input  wire logic                  i_app_tx_valid,
  output logic                       o_app_tx_ready,
  input  wire sfb_pkg::sfb_beat_s    i_app_tx_beat,
  // transmit stream to the core
  output logic                       o_tx_valid,
  input  wire logic                  i_tx_ready,
  output sfb_pkg::sfb_beat_s         o_tx_beat,
  // interrupt and error requests, one-cycle pulses; INTx status is a level
  input  wire logic                  i_msi_req,
  input  wire logic                  i_msix_req,
  input  wire logic [63:0]           i_msix_addr,
  input  wire logic [31:0]           i_msix_data,
  input  wire sfb_pkg::sfb_fn_s      i_irq_fn,
  input  wire logic                  i_intx_sts,
  input  wire logic                  i_err_cor,
  input  wire logic                  i_err_nonfatal,
  output logic                       o_irq_busy,
  // management port
  input  wire logic                  i_lmp_req,
  input  wire logic                  i_lmp_wr,
  input  wire logic                  i_lmp_to_core,
  input  wire sfb_pkg::sfb_fn_s      i_lmp_fn,
  input  wire logic [LMP_DW-1:0]     i_lmp_wdata,
  output logic                       o_lmp_ack,
  output logic [LMP_DW-1:0]          o_lmp_rdata,
  output logic                       o_core_lmp_req,
  output logic                       o_core_lmp_wr,
  output logic [LMP_DW-1:0]          o_core_lmp_wdata,
  input  wire logic                  i_core_lmp_ack,
  input  wire logic [LMP_DW-1:0]     i_core_lmp_rdata,
  // mirror of VF control fields
  input  wire logic [VF_W-1:0]       i_mir_vf,
  input  wire logic [PF_W-1:0]       i_mir_pf,
  output sfb_pkg::sfb_mirror_s       o_mirror
);
  import sfb_pkg::*;

  localparam int N_FN = N_PF + N_PF * N_VF;
  localparam int FN_W = $clog2(N_FN);
  localparam int CFG_WORDS = 16;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_PASS = 5'b00010, ST_DROP = 5'b00100,
    ST_CFG  = 5'b01000, ST_UR   = 5'b10000
  } sfb_rx_e;
  typedef enum logic [2:0] {
    TX_APP = 3'b001, TX_GEN = 3'b010, TX_GEN2 = 3'b100
  } sfb_tx_e;

  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // config storage: one flat array holding 16 dwords per function
  logic [31:0] cfg_mem [N_FN*CFG_WORDS];
  function automatic logic [FN_W-1:0] fn_index(input sfb_fn_s f);
    logic [31:0] r;
    r = f.vf_active ? (32'(N_PF) + 32'(f.pf) * 32'(N_VF) + 32'(f.vf)) : 32'(f.pf);
    return r[FN_W-1:0];
  endfunction
  function automatic logic [FN_W+CFG_IDX_W-1:0] cfg_addr(input sfb_fn_s f, input logic [CFG_IDX_W-1:0] i);
    return {fn_index(f), i};
  endfunction

  // rx header decode
  logic [7:0]  rx_type;
  logic [31:0] rx_addr;
  logic        rx_is_mem;
  logic        rx_is_cfg;
  logic        rx_is_mrd;
  logic [31:0] bar0_w;
  logic [31:0] bar1_w;
  logic        bar_hit;
  logic        mem_en;
  assign rx_type   = i_rx_beat.data[63:56];
  assign rx_addr   = i_rx_beat.data[31:0];
  assign rx_is_mem = (rx_type == TYP_MRD) || (rx_type == TYP_MWR);
  assign rx_is_cfg = (rx_type == TYP_CFGRD) || (rx_type == TYP_CFGWR);
  assign rx_is_mrd = (rx_type == TYP_MRD);
  assign bar0_w    = cfg_mem[cfg_addr(i_rx_fn, CFG_BAR0)];
  assign bar1_w    = cfg_mem[cfg_addr(i_rx_fn, CFG_BAR1)];
  assign mem_en    = cfg_mem[cfg_addr(i_rx_fn, CFG_CMD)][CMD_MEM_EN_BIT];
  // compare address against both BARs of the targeted function
  assign bar_hit = mem_en && ((((rx_addr ^ bar0_w) & BAR_SIZE_MASK) == 32'h0) ||
                              (((rx_addr ^ bar1_w) & BAR_SIZE_MASK) == 32'h0));

  sfb_rx_e    rx_st_q;
  logic       sk_valid;
  logic       sk_ready;
  logic       pass_beat;
  logic [DATA_W+1:0] sk_in;
  logic       sk_out_valid;
  sfb_beat_s  sk_beat;
  logic       cfg_busy_q;
  logic       ur_busy_q;
  logic       hdr;

  assign hdr = i_rx_valid && i_rx_beat.sop && (rx_st_q == ST_IDLE);
  // beats go straight into a fifo, order kept, contents untouched
  assign pass_beat = i_rx_valid && ((rx_st_q == ST_PASS) ||
                     (hdr && !rx_is_cfg && (!rx_is_mem || bar_hit)));
  assign sk_valid  = pass_beat;
  assign o_rx_ready = (rx_st_q == ST_PASS) ? sk_ready :
                      (rx_st_q == ST_DROP) ? 1'b1 :
                      (rx_st_q == ST_IDLE) ? (sk_ready && !cfg_busy_q && !ur_busy_q) : 1'b0;
  // no per-request state is kept; completions are handed on as they come
  assign sk_in = {i_rx_beat.sop, i_rx_beat.eop, i_rx_beat.data};

  sfb_skid #(.W(DATA_W+2)) u_rx_buf (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_valid (sk_valid && o_rx_ready),
    .o_ready (sk_ready),
    .i_data  (sk_in),
    .o_valid (sk_out_valid),
    .i_ready (i_app_rx_ready),
    .o_data  (sk_beat)
  );
  assign o_app_rx_valid = sk_out_valid;
  assign o_app_rx_beat  = sk_beat;

  logic              gen_done;
  logic [15:0]       req_id_q;
  logic [7:0]        req_tag_q;
  logic              cfg_wr_q;
  sfb_fn_s           cfg_fn_q;
  logic [31:0]       cfg_wdata_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q         <= ST_IDLE;
      o_app_rx_vf_hit <= 1'b0;
      cfg_busy_q      <= 1'b0;
      ur_busy_q       <= 1'b0;
      req_id_q        <= 16'h0;
      req_tag_q       <= 8'h0;
      cfg_wr_q        <= 1'b0;
      cfg_fn_q        <= '0;
      cfg_wdata_q     <= 32'h0;
    end else begin
      if (gen_done) begin
        cfg_busy_q <= 1'b0;
        ur_busy_q  <= 1'b0;
      end
      unique case (rx_st_q)
        ST_IDLE: if (i_rx_valid && o_rx_ready && i_rx_beat.sop) begin
          req_id_q  <= i_rx_beat.data[47:32];
          req_tag_q <= i_rx_beat.data[55:48];
          cfg_fn_q  <= i_rx_fn;
          if (rx_is_cfg) begin
            cfg_busy_q  <= 1'b1;
            cfg_wr_q    <= (rx_type == TYP_CFGWR);
            cfg_wdata_q <= rx_addr;
            rx_st_q     <= i_rx_beat.eop ? ST_IDLE : ST_CFG;
          end else if (rx_is_mem && !bar_hit) begin
            ur_busy_q <= rx_is_mrd;
            rx_st_q   <= i_rx_beat.eop ? ST_IDLE : ST_DROP;
          end else begin
            o_app_rx_vf_hit <= rx_is_mem && i_rx_fn.vf_active;
            rx_st_q         <= i_rx_beat.eop ? ST_IDLE : ST_PASS;
          end
        end
        ST_PASS: if (i_rx_valid && o_rx_ready && i_rx_beat.eop) rx_st_q <= ST_IDLE;
        ST_DROP: if (i_rx_valid && i_rx_beat.eop) rx_st_q <= ST_IDLE;
        ST_CFG:  rx_st_q <= ST_IDLE;
        ST_UR:   rx_st_q <= ST_IDLE;
      endcase
    end
  end

  // management port steering
  logic lmp_cfg_ack_q;
  logic [LMP_DW-1:0] lmp_cfg_rd_q;
  assign o_core_lmp_req   = i_lmp_req && i_lmp_to_core;
  assign o_core_lmp_wr    = i_lmp_wr;
  assign o_core_lmp_wdata = i_lmp_wdata;
  assign o_lmp_ack   = i_lmp_to_core ? i_core_lmp_ack : lmp_cfg_ack_q;
  assign o_lmp_rdata = i_lmp_to_core ? i_core_lmp_rdata : lmp_cfg_rd_q;

  always_ff @(posedge i_clk) begin
    if (i_lmp_req && !i_lmp_to_core && i_lmp_wr)
      cfg_mem[cfg_addr(i_lmp_fn, i_lmp_fn.idx)] <= i_lmp_wdata;
    else if (gen_done && cfg_busy_q && cfg_wr_q)
      cfg_mem[cfg_addr(cfg_fn_q, cfg_fn_q.idx)] <= cfg_wdata_q;
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lmp_cfg_ack_q <= 1'b0;
      lmp_cfg_rd_q  <= '0;
    end else begin
      lmp_cfg_ack_q <= i_lmp_req && !i_lmp_to_core;
      lmp_cfg_rd_q  <= cfg_mem[cfg_addr(i_lmp_fn, i_lmp_fn.idx)];
    end
  end

  // mirror port of VF control fields
  sfb_fn_s mir_fn;
  assign mir_fn = '{vf_active: 1'b1, pf: i_mir_pf, vf: i_mir_vf, idx: CFG_CMD};
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) o_mirror <= '0;
    else begin
      o_mirror.pf        <= i_mir_pf;
      o_mirror.vf        <= i_mir_vf;
      o_mirror.vf_active <= 1'b1;
      o_mirror.mem_en    <= cfg_mem[cfg_addr(mir_fn, CFG_CMD)][CMD_MEM_EN_BIT];
      o_mirror.intx_dis  <= cfg_mem[cfg_addr(mir_fn, CFG_CMD)][CMD_INTX_DIS_BIT];
      o_mirror.devctl    <= cfg_mem[cfg_addr(mir_fn, CFG_DEVCTL)][15:0];
    end
  end

  // pending bridge-generated message: latched requests
  logic msi_p_q, msix_p_q, intx_p_q, intx_lvl_q, cor_p_q, nf_p_q;
  logic [63:0] gen_addr;
  logic [31:0] gen_data;
  logic [7:0]  gen_type;
  logic        gen_any;
  sfb_fn_s     irq_fn_q;
  logic [63:0] msix_addr_q;
  logic [31:0] msix_data_q;
  sfb_tx_e     tx_st_q;
  assign gen_any = cfg_busy_q || ur_busy_q || msi_p_q || msix_p_q || intx_p_q || cor_p_q || nf_p_q;
  assign o_irq_busy = msi_p_q || msix_p_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      msi_p_q <= 1'b0; msix_p_q <= 1'b0; intx_p_q <= 1'b0;
      intx_lvl_q <= 1'b0; cor_p_q <= 1'b0; nf_p_q <= 1'b0;
      irq_fn_q <= '0; msix_addr_q <= 64'h0; msix_data_q <= 32'h0;
    end else begin
      // a new INTx or error request wins over the clear of the one being sent; MSI and MSI-X requests are refused while o_irq_busy
      if (gen_done && !cfg_busy_q && !ur_busy_q) begin
        if (msi_p_q) msi_p_q <= 1'b0;
        else if (msix_p_q) msix_p_q <= 1'b0;
        else if (intx_p_q) intx_p_q <= 1'b0;
        else if (cor_p_q) cor_p_q <= 1'b0;
        else nf_p_q <= 1'b0;
      end
      if (i_msi_req && !i_irq_fn.vf_active && !o_irq_busy) begin
        msi_p_q <= 1'b1; irq_fn_q <= i_irq_fn;
      end
      if (i_msix_req && !o_irq_busy) begin
        msix_p_q <= 1'b1; irq_fn_q <= i_irq_fn;
        msix_addr_q <= i_msix_addr; msix_data_q <= i_msix_data;
      end
      intx_lvl_q <= i_intx_sts;
      if (i_intx_sts != intx_lvl_q) intx_p_q <= 1'b1;
      if (i_err_cor) cor_p_q <= 1'b1;
      if (i_err_nonfatal) nf_p_q <= 1'b1;
    end
  end

  // header of bridge traffic, fixed priority: config cpl, UR, then messages
  always_comb begin
    gen_type = TYP_MSG;
    gen_addr = 64'h0;
    gen_data = 32'h0;
    if (cfg_busy_q) begin
      gen_type = cfg_wr_q ? TYP_CPL : TYP_CPLD;
      gen_addr = {req_id_q, req_tag_q, 5'h0, CPL_SC, 32'h0};
      gen_data = cfg_mem[cfg_addr(cfg_fn_q, cfg_fn_q.idx)];
    end else if (ur_busy_q) begin
      gen_type = TYP_CPL;
      gen_addr = {req_id_q, req_tag_q, 5'h0, CPL_UR, 32'h0};
    end else if (msi_p_q) begin
      gen_type = TYP_MWR;
      gen_addr = {32'h0, cfg_mem[cfg_addr(irq_fn_q, CFG_MSI_AD)]};
      gen_data = cfg_mem[cfg_addr(irq_fn_q, CFG_MSI_DT)];
    end else if (msix_p_q) begin
      gen_type = TYP_MWR;
      gen_addr = msix_addr_q;
      gen_data = msix_data_q;
    end else if (intx_p_q) begin
      gen_addr = {56'h0, intx_lvl_q ? MSG_ASSERT_INTA : MSG_DEASSERT_INTA};
    end else if (cor_p_q) begin
      gen_addr = {56'h0, MSG_ERR_COR};
    end else begin
      gen_addr = {56'h0, MSG_ERR_NONFATAL};
    end
  end

  // transmit mux: app packets are never split, bridge packets take two beats
  logic app_in_pkt_q;
  assign gen_done = (tx_st_q == TX_GEN2) && i_tx_ready;
  always_comb begin
    o_tx_valid     = 1'b0;
    o_tx_beat      = '0;
    o_app_tx_ready = 1'b0;
    unique case (tx_st_q)
      TX_APP: begin
        o_tx_valid     = i_app_tx_valid && (app_in_pkt_q || !gen_any);
        o_tx_beat      = i_app_tx_beat;
        o_app_tx_ready = i_tx_ready && (app_in_pkt_q || !gen_any);
      end
      TX_GEN: begin
        o_tx_valid = 1'b1;
        o_tx_beat  = '{sop: 1'b1, eop: 1'b0, data: {gen_type, gen_addr[55:0]}};
      end
      TX_GEN2: begin
        o_tx_valid = 1'b1;
        o_tx_beat  = '{sop: 1'b0, eop: 1'b1, data: {gen_addr[63:56], 24'h0, gen_data}};
      end
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q      <= TX_APP;
      app_in_pkt_q <= 1'b0;
    end else begin
      if (o_app_tx_ready && i_app_tx_valid)
        app_in_pkt_q <= !i_app_tx_beat.eop;
      unique case (tx_st_q)
        TX_APP:  if (gen_any && !app_in_pkt_q && !(i_app_tx_valid && o_app_tx_ready)) tx_st_q <= TX_GEN;
        TX_GEN:  if (i_tx_ready) tx_st_q <= TX_GEN2;
        TX_GEN2: if (i_tx_ready) tx_st_q <= TX_APP;
      endcase
    end
  end

  AST_MISS_DROPPED: assert property (@(posedge i_clk) disable iff (!rst_n)
    hdr && rx_is_mem && !bar_hit |-> !sk_valid) else $error("bar miss passed on");
  AST_CFG_NOT_PASSED: assert property (@(posedge i_clk) disable iff (!rst_n)
    hdr && rx_is_cfg |-> !sk_valid) else $error("config tlp reached app");
  AST_UR_SENT: assert property (@(posedge i_clk) disable iff (!rst_n)
    $rose(ur_busy_q) |-> ##[1:400] (gen_done && ur_busy_q)) else $error("ur not sent");
  AST_CFG_CPL: assert property (@(posedge i_clk) disable iff (!rst_n)
    $rose(cfg_busy_q) |-> ##[1:400] !cfg_busy_q) else $error("config completion missing");
  AST_MSI_PF_ONLY: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_msi_req && i_irq_fn.vf_active |=> !$rose(msi_p_q)) else $error("msi for vf");
  AST_GEN_FRAME: assert property (@(posedge i_clk) disable iff (!rst_n)
    tx_st_q == TX_GEN && i_tx_ready |=> tx_st_q == TX_GEN2) else $error("bridge packet split");
  AST_APP_HOLD: assert property (@(posedge i_clk) disable iff (!rst_n)
    tx_st_q != TX_APP |-> !o_app_tx_ready) else $error("app accepted during bridge packet");
  AST_LMP_ROUTE: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_lmp_req && !i_lmp_to_core |-> !o_core_lmp_req ##1 o_lmp_ack) else $error("lmp misrouted");
endmodule
`default_nettype wire

/* File: sfb_app_model.sv */
// application-side model: receive sink that can stall, one-packet transmit source
`timescale 1ns/10ps
`default_nettype none
module sfb_app_model (
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_stall,
  input  wire logic          i_send,
  output logic               o_rx_ready,
  output logic               o_tx_valid,
  input  wire logic          i_tx_ready,
  output sfb_pkg::sfb_beat_s o_tx_beat
);
  import sfb_pkg::*;

  // a full stall lets the two-entry buffer fill so the bridge has to refuse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_ready <= 1'b0;
    end else begin
      o_rx_ready <= !i_stall;
    end
  end

  // idle beats are inverted every cycle so nobody can lean on stale data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_valid <= 1'b0;
      o_tx_beat  <= '0;
    end else if (!o_tx_valid && i_send) begin
      o_tx_valid <= 1'b1;
      o_tx_beat  <= '{sop: 1'b1, eop: 1'b0, data: {32'h0000_000f, TYP_MWR, 24'h000001}};
    end else if (o_tx_valid && i_tx_ready && o_tx_beat.sop) begin
      o_tx_beat  <= '{sop: 1'b0, eop: 1'b1, data: {32'h1234_5678, 32'h0030_0000}};
    end else if (o_tx_valid && i_tx_ready) begin
      o_tx_valid <= 1'b0;
      o_tx_beat  <= ~o_tx_beat;
    end else if (!o_tx_valid) begin
      o_tx_beat  <= ~o_tx_beat;
    end
  end
endmodule
`default_nettype wire

/* File: sriov_function_bridge_bench.sv */
// self-checking bench for the function bridge
`timescale 1ns/10ps
`default_nettype none
module sriov_function_bridge_bench;
  import sfb_pkg::*;
  typedef struct packed {
    logic [2:0] kind;
    logic [7:0] typ;
    logic       vf;
    logic [2:0] n_in;
    logic [2:0] n_fwd;
    logic [2:0] n_tx;
    logic [7:0] tx_typ;
  } sfb_row_s;

  logic        clk, arst_n, rx_valid, rx_ready, arx_valid, arx_ready, vf_hit, atx_valid, atx_ready;
  logic        tx_valid, tx_ready, msi, msix, intx, ecor, enf, busy, lreq, lwr, lcore, lack;
  logic        clreq, clwr, clack, creq_seen, stall, send;
  logic [31:0] lwdata, lrdata, clwdata, rd;
  logic [10:0] mvf;
  logic [2:0]  mpf;
  sfb_beat_s   rx_beat, arx_beat, atx_beat, tx_beat;
  sfb_fn_s     rx_fn, irq_fn, lfn, fn;
  sfb_mirror_s mir;
  sfb_beat_s   txq[$], rxq[$], sentq[$];
  int          n_errors = 0;
  int          n_compared = 0;
  // kind: 0 receive packet, 1 intx edge, 2 correctable, 3 non-fatal, 4 msi, 5 msi-x
  sfb_row_s rows [13] = '{
    '{3'd0, TYP_CPLD, 1'b0, 3'd3, 3'd3, 3'd0, 8'h00},
    '{3'd0, TYP_MSG, 1'b0, 3'd2, 3'd2, 3'd0, 8'h00},
    '{3'd0, TYP_MRD, 1'b0, 3'd2, 3'd0, 3'd2, TYP_CPL},
    '{3'd0, TYP_CFGRD, 1'b0, 3'd2, 3'd0, 3'd2, TYP_CPLD},
    '{3'd0, TYP_CFGWR, 1'b1, 3'd2, 3'd0, 3'd2, TYP_CPL},
    '{3'd1, 8'h00, 1'b0, 3'd0, 3'd0, 3'd2, TYP_MSG},
    '{3'd1, 8'h00, 1'b0, 3'd0, 3'd0, 3'd2, TYP_MSG},
    '{3'd2, 8'h00, 1'b0, 3'd0, 3'd0, 3'd2, TYP_MSG},
    '{3'd3, 8'h00, 1'b0, 3'd0, 3'd0, 3'd2, TYP_MSG},
    '{3'd4, 8'h00, 1'b0, 3'd0, 3'd0, 3'd2, TYP_MWR},
    '{3'd4, 8'h00, 1'b1, 3'd0, 3'd0, 3'd0, 8'h00},
    '{3'd5, 8'h00, 1'b1, 3'd0, 3'd0, 3'd2, TYP_MWR},
    '{3'd5, 8'h00, 1'b0, 3'd0, 3'd0, 3'd2, TYP_MWR}
  };

  sfb_bridge #(.N_VF(4)) dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
    .i_rx_beat(rx_beat), .i_rx_fn(rx_fn), .o_app_rx_valid(arx_valid), .i_app_rx_ready(arx_ready),
    .o_app_rx_beat(arx_beat), .o_app_rx_vf_hit(vf_hit), .i_app_tx_valid(atx_valid),
    .o_app_tx_ready(atx_ready), .i_app_tx_beat(atx_beat), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
    .o_tx_beat(tx_beat), .i_msi_req(msi), .i_msix_req(msix), .i_msix_addr(64'h0000_0000_fee0_0000),
    .i_msix_data(32'h0000_0042), .i_irq_fn(irq_fn), .i_intx_sts(intx), .i_err_cor(ecor),
    .i_err_nonfatal(enf), .o_irq_busy(busy), .i_lmp_req(lreq), .i_lmp_wr(lwr), .i_lmp_to_core(lcore),
    .i_lmp_fn(lfn), .i_lmp_wdata(lwdata), .o_lmp_ack(lack), .o_lmp_rdata(lrdata),
    .o_core_lmp_req(clreq), .o_core_lmp_wr(clwr), .o_core_lmp_wdata(clwdata), .i_core_lmp_ack(clack),
    .i_core_lmp_rdata(32'hc0de_0001), .i_mir_vf(mvf), .i_mir_pf(mpf), .o_mirror(mir));

  sfb_app_model app (
    .i_clk(clk), .i_rst_n(arst_n), .i_stall(stall), .i_send(send), .o_rx_ready(arx_ready),
    .o_tx_valid(atx_valid), .i_tx_ready(atx_ready), .o_tx_beat(atx_beat));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) if (tx_valid && tx_ready) txq.push_back(tx_beat);
  always @(posedge clk) if (arx_valid && arx_ready) rxq.push_back(arx_beat);
  // core-side management port answers one cycle after it sees a request
  always @(posedge clk) creq_seen <= clreq;
  always_comb clack = creq_seen;

  task automatic chk(input logic [65:0] got, input logic [65:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // called at a falling edge; each beat is held until ready is seen high
  task automatic rx_send(input logic [7:0] typ, input sfb_fn_s f, input int n, input logic [31:0] addr);
    int g;
    for (int k = 0; k < n; k++) begin
      g = 0;
      {rx_valid, rx_fn} = {1'b1, f};
      rx_beat = '{sop: k == 0, eop: k == n - 1, data: (k == 0) ? {typ, 24'h1, addr} : {k, addr}};
      sentq.push_back(rx_beat);
      #1;
      while (rx_ready !== 1'b1 && g < 50) begin
        @(negedge clk);
        #1;
        g++;
      end
      if (g == 50) n_errors++;
      @(negedge clk);
    end
    rx_valid = 1'b0;
  endtask

  task automatic lmp(input logic wr, input logic core, input sfb_fn_s f, input logic [31:0] wd);
    int g = 0;
    {lreq, lwr, lcore, lfn, lwdata} = {1'b1, wr, core, f, wd};
    @(negedge clk);
    lreq = 1'b0;
    while (lack !== 1'b1 && g < 20) begin
      @(negedge clk);
      g++;
    end
    if (g == 20) n_errors++;
    rd = lrdata;
    @(negedge clk);
  endtask

  task automatic settle(input int want);
    int g = 0;
    while (txq.size() < want && g < 200) begin
      @(negedge clk);
      g++;
    end
    repeat (20) @(negedge clk);
  endtask

  initial begin
    #(40 * 20000);
    n_errors++;
    close_out();
  end

  initial begin
    {arst_n, rx_valid, tx_ready, msi, msix, intx, ecor, enf, lreq, lwr, lcore, stall, send} = '0;
    {rx_beat, rx_fn, irq_fn, lfn, lwdata, mvf, mpf} = '0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    tx_ready = 1'b1;
    repeat (4) @(negedge clk);
    chk({arx_valid, tx_valid, mir.pf, mir.vf, mir.vf_active}, {2'b00, 3'd0, 11'd0, 1'b1}, "idle after reset");
    // memory space of function 0 starts disabled so its reads miss
    lmp(1'b1, 1'b0, '{1'b0, 3'd0, 11'd0, CFG_CMD}, 32'h0);
    foreach (rows[i]) begin
      txq.delete();
      rxq.delete();
      sentq.delete();
      fn = '{rows[i].vf, 3'd0, 11'd1, CFG_CMD};
      irq_fn = fn;
      case (rows[i].kind)
        3'd0: rx_send(rows[i].typ, fn, rows[i].n_in, 32'h0);
        3'd1: intx = ~intx;
        3'd2: ecor = 1'b1;
        3'd3: enf = 1'b1;
        3'd4: msi = 1'b1;
        default: msix = 1'b1;
      endcase
      @(negedge clk);
      {ecor, enf, msi, msix} = 4'h0;
      settle(rows[i].n_tx);
      chk(rxq.size(), rows[i].n_fwd, "forwarded beats");
      chk(txq.size(), rows[i].n_tx, "tx beats");
      if (txq.size() == 2) chk({txq[0].sop, txq[1].eop, txq[0].data[63:56]}, {2'b11, rows[i].tx_typ}, "tx pkt");
      if (rows[i].n_fwd > 0) foreach (rxq[j]) chk(rxq[j], sentq[j], "rx beat");
    end
    // receiver stalls while bridge traffic and an app packet compete for transmit
    txq.delete();
    rxq.delete();
    sentq.delete();
    {stall, send, intx} = 3'b111;
    @(negedge clk);
    send = 1'b0;
    fn = '0;
    // the stall outlasts the buffer depth, then lifts while the sender waits
    fork
      begin
        repeat (8) @(negedge clk);
        stall = 1'b0;
      end
    join_none
    rx_send(TYP_CPLD, fn, 3, 32'h0);
    rx_send(TYP_CPL, fn, 2, 32'h0);
    settle(4);
    chk(rxq.size(), 5, "ordered count");
    foreach (sentq[j]) chk(rxq[j], sentq[j], "ordered beat");
    chk({txq[0].sop, txq[1].eop, txq[2].sop, txq[3].eop}, 4'hf, "tx packets whole");
    // BAR matching for one physical and one virtual function
    for (int v = 0; v < 2; v++) begin
      fn = '{v[0], 3'd0, 11'(v), CFG_CMD};
      lmp(1'b1, 1'b0, fn, 32'h0000_0002);
      fn.idx = CFG_BAR0;
      lmp(1'b1, 1'b0, fn, 32'h0010_0000 << v);
      lmp(1'b0, 1'b0, fn, 32'h0);
      chk(rd, 32'h0010_0000 << v, "bar readback");
      rxq.delete();
      sentq.delete();
      rx_send(TYP_MRD, fn, 2, 32'h0010_0040 << v);
      settle(0);
      chk({rxq.size(), vf_hit}, {32'd2, v[0]}, "bar hit");
    end
    fn.idx = CFG_DEVCTL;
    lmp(1'b1, 1'b0, fn, 32'h0000_2810);
    mvf = 11'd1;
    repeat (2) @(negedge clk);
    chk({mir.vf, mir.mem_en, mir.devctl}, {11'd1, 1'b1, 16'h2810}, "mirror");
    lmp(1'b0, 1'b1, fn, 32'h0);
    chk(rd, 32'hc0de_0001, "core read");
    close_out();
  end
endmodule
`default_nettype wire
